// [src/hfs_semaphore.v]
// Host/firmware semaphore registers: host-host read-to-set lock, host-firmware
// lock, firmware lock with mode and valid fields.
// Assumes single-cycle read/write strobes from host and firmware on clk, and an
// asynchronous active-low host bus reset pin.
`timescale 1ns/1ps
`include "hfs_map.vh"

module hfs_semaphore
#(
   parameter integer HOLD_CYCLES = `HFS_HOLD_CYCLES
)
(
   input  wire                   clk,
   input  wire                   nrst,
   input  wire                   host_bus_rst_n,
   input  wire                   host_rd,
   input  wire                   host_wr,
   input  wire [`HFS_ADDR_W-1:0] host_addr,
   input  wire [31:0]            host_wdata,
   output reg  [31:0]            host_rdata,
   output reg                    host_rvalid,
   input  wire                   fw_rd,
   input  wire                   fw_wr,
   input  wire [`HFS_ADDR_W-1:0] fw_addr,
   input  wire [31:0]            fw_wdata,
   output reg  [31:0]            fw_rdata,
   output reg                    fw_rvalid
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   reg       hh_lock_reg;
   reg       hh_lock_next;
   reg       hf_lock_reg;
   reg       hf_lock_next;
   reg       fw_lock_reg;
   reg       fw_lock_next;
   reg [2:0] mode_reg;
   reg [2:0] mode_next;
   reg       valid_reg;
   reg       valid_next;

   wire bus_rst_n_sync;
   wire hold_expired;

   reg host_sel_hs;
   reg host_sel_fs;
   reg fw_sel_hs;
   reg fw_sel_fs;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function [31:0] host_sem_word;
      input hh;
      input hf;
      begin
         host_sem_word = `HFS_DATA_RST;
         host_sem_word[`HFS_HH_LOCK_POS] = hh;
         host_sem_word[`HFS_HF_LOCK_POS] = hf;
      end
   endfunction

   function [31:0] fw_sem_word;
      input       lk;
      input [2:0] md;
      input       vl;
      begin
         fw_sem_word = `HFS_DATA_RST;
         fw_sem_word[`HFS_FW_LOCK_POS] = lk;
         fw_sem_word[`HFS_MODE_MSB:`HFS_MODE_LSB] = md;
         fw_sem_word[`HFS_VALID_POS] = vl;
      end
   endfunction

   function mode_legal;
      input [2:0] md;
      begin
         mode_legal = (md == `HFS_MODE_NONE) || (md == `HFS_MODE_PROXY) || (md == `HFS_MODE_HOST_IF);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Submodules

   hfs_sync u_bus_rst_sync
   (
      .clk       (clk),
      .nrst      (nrst),
      .pin_in    (host_bus_rst_n),
      .level_out (bus_rst_n_sync)
   );

   hfs_timer #(.HOLD_CYCLES(HOLD_CYCLES)) u_hold_timer
   (
      .clk     (clk),
      .nrst    (nrst),
      .run     (hf_lock_reg),
      .expired (hold_expired)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always @*
   begin
      host_sel_hs  = (host_addr == `HFS_HOST_SEM_OFS);
      host_sel_fs  = (host_addr == `HFS_FW_SEM_OFS);
      fw_sel_hs    = (fw_addr == `HFS_HOST_SEM_OFS);
      fw_sel_fs    = (fw_addr == `HFS_FW_SEM_OFS);
      hh_lock_next = hh_lock_reg;
      hf_lock_next = hf_lock_reg;
      fw_lock_next = fw_lock_reg;
      mode_next    = mode_reg;
      valid_next   = valid_reg;

      // A read is taken before any write in the same cycle, so read-to-set wins
      if (host_rd && host_sel_hs)
         hh_lock_next = 1'b1;
      else if (host_wr && host_sel_hs)
      begin
         if (!host_wdata[`HFS_HH_LOCK_POS])
            hh_lock_next = 1'b0;
         // Reserved bits of the write are dropped
         if (!host_wdata[`HFS_HF_LOCK_POS])
            hf_lock_next = 1'b0;
         else if (!fw_lock_reg)
            hf_lock_next = 1'b1;
      end

      // Firmware side of firmware_semaphore; host writes there are ignored
      if (fw_wr && fw_sel_fs)
      begin
         if (!fw_wdata[`HFS_FW_LOCK_POS])
            fw_lock_next = 1'b0;
         else if (!hf_lock_reg && !hf_lock_next)
            fw_lock_next = 1'b1;
         else if (hold_expired)
         begin
            fw_lock_next = 1'b1;
            hf_lock_next = 1'b0;
         end
         if (mode_legal(fw_wdata[`HFS_MODE_MSB:`HFS_MODE_LSB]))
            mode_next = fw_wdata[`HFS_MODE_MSB:`HFS_MODE_LSB];
         valid_next = fw_wdata[`HFS_VALID_POS];
      end
      // Firmware writes to host_semaphore have no effect

      // Host bus reset holds both host locks clear while asserted
      if (!bus_rst_n_sync)
      begin
         hh_lock_next = 1'b0;
         hf_lock_next = 1'b0;
         valid_next   = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers and read data

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hh_lock_reg <= `HFS_LOCK_RST;
         hf_lock_reg <= `HFS_LOCK_RST;
         fw_lock_reg <= `HFS_LOCK_RST;
         mode_reg    <= `HFS_MODE_RST;
         valid_reg   <= `HFS_VALID_RST;
         host_rdata  <= `HFS_DATA_RST;
         host_rvalid <= 1'h0;
         fw_rdata    <= `HFS_DATA_RST;
         fw_rvalid   <= 1'h0;
      end
      else
      begin
         hh_lock_reg <= hh_lock_next;
         hf_lock_reg <= hf_lock_next;
         fw_lock_reg <= fw_lock_next;
         mode_reg    <= mode_next;
         valid_reg   <= valid_next;
         host_rvalid <= host_rd;
         fw_rvalid   <= fw_rd;
         // Read data shows the value before this cycle's set
         if (host_rd)
         begin
            if (host_sel_hs)
               host_rdata <= host_sem_word(hh_lock_reg, hf_lock_reg);
            else if (host_sel_fs)
               host_rdata <= fw_sem_word(fw_lock_reg, mode_reg, valid_reg);
            else
               host_rdata <= `HFS_DATA_RST;
         end
         if (fw_rd)
         begin
            if (fw_sel_hs)
               fw_rdata <= host_sem_word(hh_lock_reg, hf_lock_reg);
            else if (fw_sel_fs)
               fw_rdata <= fw_sem_word(fw_lock_reg, mode_reg, valid_reg);
            else
               fw_rdata <= `HFS_DATA_RST;
         end
      end
   end

endmodule

// [shared/hfs_map.vh]
// Constants for the host/firmware semaphore block: offsets, fields, resets, timing.
// Assumes a 20 MHz clock and byte addresses on the host and firmware ports.
`ifndef HFS_MAP_VH
`define HFS_MAP_VH

`define HFS_ADDR_W           16
`define HFS_HOST_SEM_OFS     16'h5b50
`define HFS_FW_SEM_OFS       16'h5b54

`define HFS_HH_LOCK_POS      0
`define HFS_HF_LOCK_POS      1
`define HFS_FW_LOCK_POS      0
`define HFS_MODE_LSB         1
`define HFS_MODE_MSB         3
`define HFS_VALID_POS        15

`define HFS_MODE_NONE        3'h0
`define HFS_MODE_PROXY       3'h1
`define HFS_MODE_HOST_IF     3'h4

`define HFS_LOCK_RST         1'h0
`define HFS_MODE_RST         3'h0
`define HFS_VALID_RST        1'h0
`define HFS_DATA_RST         32'h0000_0000

`define HFS_CLK_KHZ          20000
`define HFS_HOLD_TIME_MS     10
`define HFS_HOLD_CYCLES      (`HFS_HOLD_TIME_MS * `HFS_CLK_KHZ)

`endif

// [src/hfs_sync.v]
// Three-stage synchroniser for a pin level, with agreement filter.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ps
`include "hfs_map.vh"

module hfs_sync
(
   input  wire clk,
   input  wire nrst,
   input  wire pin_in,
   output reg  level_out
);

   reg s1_reg;
   reg s2_reg;
   reg s3_reg;

   // First stage feeds only the second; reset value reads as bus reset asserted
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s1_reg    <= 1'h0;
         s2_reg    <= 1'h0;
         s3_reg    <= 1'h0;
         level_out <= 1'h0;
      end
      else
      begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg)
            level_out <= s3_reg;
      end
   end

endmodule

// [src/hfs_timer.v]
// Hold timer for the host-firmware lock: flags a hold longer than HOLD_CYCLES.
// Assumes run is a same-clock level that stays high while the lock is held.
`timescale 1ns/1ps
`include "hfs_map.vh"

module hfs_timer
#(
   parameter integer HOLD_CYCLES = `HFS_HOLD_CYCLES,
   parameter integer CNT_W       = 20
)
(
   input  wire clk,
   input  wire nrst,
   input  wire run,
   output reg  expired
);

   reg [CNT_W-1:0] cnt_reg;

   // Counter saturates so a long hold never wraps back to not-expired
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_reg <= {CNT_W{1'b0}};
         expired <= 1'h0;
      end
      else if (!run)
      begin
         cnt_reg <= {CNT_W{1'b0}};
         expired <= 1'h0;
      end
      else if (cnt_reg < HOLD_CYCLES[CNT_W-1:0])
      begin
         cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
         expired <= 1'h0;
      end
      else
         expired <= 1'h1;
   end

endmodule

// [dv/hfs_semaphore_monitor.sv]
// Assertions on the semaphore block ports.
// Assumes hfs_map.vh on the include path; bound to every hfs_semaphore.
`timescale 1ns/1ps
`include "hfs_map.vh"
////////////////////////////////////////////////////////////
module hfs_semaphore_monitor
#(
   parameter integer HOLD_CYCLES = 20
)
(
   input logic        clk,
   input logic        nrst,
   input logic        host_bus_rst_n,
   input logic        host_rd,
   input logic        host_wr,
   input logic [15:0] host_addr,
   input logic [31:0] host_wdata,
   input logic [31:0] host_rdata,
   input logic        host_rvalid,
   input logic        fw_rd,
   input logic        fw_wr,
   input logic [15:0] fw_addr,
   input logic [31:0] fw_wdata,
   input logic [31:0] fw_rdata,
   input logic        fw_rvalid
);
   localparam logic [15:0] H = `HFS_HOST_SEM_OFS;
   localparam logic [15:0] F = `HFS_FW_SEM_OFS;
   logic [2:0] up_cnt;
   logic       hs_rd;
   assign hs_rd = host_rd && host_addr == H;
   // Bus reset sync takes a few cycles, so lock checks wait until it settles
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
         up_cnt <= 3'h0;
      else if (!host_bus_rst_n)
         up_cnt <= 3'h0;
      else if (up_cnt != 3'h7)
         up_cnt <= up_cnt + 3'h1;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////
   a_host_answer: assert property (host_rd |=> host_rvalid)
      else $error("host read got no answer");
   a_host_cause: assert property (host_rvalid |-> $past(host_rd))
      else $error("host answer without read");
   a_fw_answer: assert property (fw_rd |=> fw_rvalid)
      else $error("firmware read got no answer");
   a_rdata_holds: assert property (!host_rd |=> $stable(host_rdata))
      else $error("host read data moved");
   a_unmapped_zero: assert property (host_rd && host_addr != H && host_addr != F |=> host_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_reserved_zero: assert property (hs_rd |=> host_rdata[31:2] == 30'h0)
      else $error("reserved bits not zero");
   a_second_read_set: assert property ((up_cnt == 3'h7 && hs_rd) ##1 hs_rd |=> host_rdata[0])
      else $error("second read saw lock clear");
   a_bus_rst_clear: assert property ((!host_bus_rst_n) [*6] ##0 hs_rd |=> host_rdata[1:0] == 2'h0)
      else $error("locks not cleared by bus reset");
   cover property (hs_rd ##1 hs_rd);
   cover property ((!host_bus_rst_n) [*6] ##0 hs_rd);
   cover property (fw_wr && fw_addr == F);
endmodule

bind hfs_semaphore hfs_semaphore_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) u_mon (.clk, .nrst, .host_bus_rst_n,
   .host_rd, .host_wr, .host_addr, .host_wdata, .host_rdata, .host_rvalid,
   .fw_rd, .fw_wr, .fw_addr, .fw_wdata, .fw_rdata, .fw_rvalid);

// [dv/tb_top.sv]
// Directed bench for the semaphore block through its host and firmware ports.
// Assumes hfs_map.vh on the include path.
`timescale 1ns/1ps
`include "hfs_map.vh"
////////////////////////////////////////////////////////////
module tb_top;
   localparam int HOLD = 20;
   localparam logic [15:0] H = `HFS_HOST_SEM_OFS;
   localparam logic [15:0] F = `HFS_FW_SEM_OFS;
   logic clk = 1'b0, nrst = 1'b0, host_bus_rst_n = 1'b1;
   logic host_rd = 1'b0, host_wr = 1'b0, fw_rd = 1'b0, fw_wr = 1'b0;
   logic [15:0] host_addr = 16'h0, fw_addr = 16'h0;
   logic [31:0] host_wdata = 32'h0, fw_wdata = 32'h0, host_rdata, fw_rdata;
   logic host_rvalid, fw_rvalid;
   logic [2:0] m_exp;
   int bad_count = 0, check_count = 0, cyc = 0;

   hfs_semaphore #(.HOLD_CYCLES(HOLD)) DUT (.clk, .nrst, .host_bus_rst_n, .host_rd, .host_wr,
      .host_addr, .host_wdata, .host_rdata, .host_rvalid, .fw_rd, .fw_wr, .fw_addr,
      .fw_wdata, .fw_rdata, .fw_rvalid);

   initial forever #25 clk = ~clk;
   ////////////////////////////////////////////////////////////
   task finish_test();
      $display("Checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task check(input logic [32:0] got, input logic [32:0] exp);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One access; reads compare answer flag and data one cycle later
   task acc(input bit f, input bit wr, input logic [15:0] a, input logic [31:0] d, input logic [31:0] e);
      @(posedge clk);
      if (f)
         {fw_wr, fw_rd, fw_addr, fw_wdata} <= {wr, !wr, a, d};
      else
         {host_wr, host_rd, host_addr, host_wdata} <= {wr, !wr, a, d};
      @(posedge clk);
      {host_rd, host_wr, fw_rd, fw_wr} <= 4'h0;
      #1;
      if (!wr)
         check(f ? {fw_rvalid, fw_rdata} : {host_rvalid, host_rdata}, {1'b1, e});
   endtask

   // Hang guard, well above the under two hundred cycles the run needs
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         bad_count++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (6) @(posedge clk);
      acc(0, 0, H, 0, 0);
      acc(0, 0, H, 0, 32'h1);
      acc(0, 1, H, 0, 0);
      acc(0, 0, H, 0, 0);
      acc(0, 0, 16'h5b58, 0, 0);
      acc(0, 1, H, 0, 0);
      // Firmware reads must neither set the host-host lock nor show unmapped data
      acc(1, 0, H, 0, 0);
      acc(1, 0, 16'h5b58, 0, 0);
      @(posedge clk);
      host_rd <= 1'b1;
      host_addr <= H;
      @(posedge clk);
      #1 check({host_rvalid, host_rdata}, 33'h1_0000_0000);
      @(posedge clk);
      host_rd <= 1'b0;
      #1 check({host_rvalid, host_rdata}, 33'h1_0000_0001);
      acc(0, 1, F, 32'hffff_ffff, 0);
      acc(0, 0, F, 0, 0);
      m_exp = 3'h0;
      for (int m = 0; m < 8; m++)
      begin
         acc(1, 1, F, m << 1, 0);
         if (m == 0 || m == 1 || m == 4)
            m_exp = m[2:0];
         acc(0, 0, F, 0, {28'h0, m_exp, 1'b0});
      end
      acc(1, 1, F, 32'h1, 0);
      acc(0, 1, H, 32'h2, 0);
      acc(0, 0, H, 0, 0);
      acc(1, 1, F, 0, 0);
      acc(0, 1, H, 32'h2, 0);
      acc(0, 0, H, 0, 32'h2);
      acc(1, 1, F, 32'h1, 0);
      acc(1, 0, F, 0, 0);
      acc(1, 1, H, 0, 0);
      acc(0, 0, H, 0, 32'h3);
      repeat (HOLD + 5) @(posedge clk);
      acc(1, 1, F, 32'h1, 0);
      acc(1, 0, F, 0, 32'h1);
      acc(0, 0, H, 0, 32'h1);
      acc(1, 1, F, 32'h8000, 0);
      acc(0, 1, H, 32'h2, 0);
      acc(1, 0, F, 0, 32'h8000);
      @(posedge clk);
      host_bus_rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      acc(0, 0, H, 0, 0);
      @(posedge clk);
      host_bus_rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      acc(0, 0, H, 0, 0);
      acc(0, 0, F, 0, 0);
      finish_test();
   end
endmodule
